//--- common/xfer_launch_pkg.sv
// constants and types for the host transfer launch block
package xfer_launch_pkg;
	// register offsets on the parallel port
	localparam logic [7:0] SET_A_CTRL_OFS = 8'h00;
	localparam logic [7:0] SET_A_PTR_OFS  = 8'h01;
	localparam logic [7:0] SET_B_CTRL_OFS = 8'h08;
	localparam logic [7:0] SET_B_PTR_OFS  = 8'h09;
	localparam logic [7:0] FEATURE_OFS    = 8'h0F;
	// transfer control field positions
	localparam int PREAMBLE_BIT = 7;
	localparam int TOGGLE_BIT   = 6;
	localparam int SOF_SYNC_BIT = 5;
	localparam int ISO_BIT      = 4;
	localparam int RSVD_BIT     = 3;
	localparam int DIR_BIT      = 2;
	localparam int ENABLE_BIT   = 1;
	localparam int ARM_BIT      = 0;
	// values after reset, unmapped read value and set and sync stage counts
	localparam logic       ARM_RESET  = 1'b0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic       FLAG_RESET    = 1'b0;
	localparam logic       STROBE_RESET  = 1'b1;
	localparam logic       LAST_B_RESET  = 1'b1;
	localparam int SET_COUNT = 2;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		LAUNCH_IDLE = 2'b00,
		LAUNCH_WAIT_SOF = 2'b11,
		LAUNCH_BUSY = 2'b01
	} launch_state_t;
endpackage

//--- common/set_launch_if.sv
// carrier between the launch logic and one register set
`timescale 1ns/100ps
interface set_launch_if;
	logic       wrCtrl;
	logic       wrPtr;
	logic [7:0] wrData;
	logic       clearArm;
	logic [7:0] ctrl;
	logic [7:0] ptr;

	modport owner (output wrCtrl, output wrPtr, output wrData, output clearArm, input ctrl, input ptr);
	modport holder (input wrCtrl, input wrPtr, input wrData, input clearArm, output ctrl, output ptr);
endinterface

//--- logic/transfer_set.sv
// one transfer register set: control byte and buffer pointer
`timescale 1ns/100ps
module transfer_set
	import xfer_launch_pkg::*;
(
	// clocking
	input wire logic    mclk,
	input wire logic    reset,
	input wire logic    ce,
	// holder side
	set_launch_if.holder regs
);
	logic       arm_q, arm_d;
	logic [7:1] ctrlHi_q, ctrlHi_d;
	logic [7:0] ptr_q, ptr_d;

	always_comb begin
		arm_d    = arm_q;
		ctrlHi_d = ctrlHi_q;
		ptr_d    = ptr_q;
		if (regs.clearArm) begin
			arm_d = 1'b0;
		end
		if (regs.wrCtrl) begin
			ctrlHi_d = regs.wrData[7:1];
			arm_d    = regs.wrData[ARM_BIT]; // software write wins over completion clear
		end
		if (regs.wrPtr) begin
			ptr_d = regs.wrData;
		end
	end

	// only arm has a reset value
	always_ff @(posedge mclk) begin
		if (reset) begin
			arm_q <= ARM_RESET;
		end else if (ce) begin
			arm_q <= arm_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce) begin
			ctrlHi_q <= ctrlHi_d;
			ptr_q    <= ptr_d;
		end
	end

	assign regs.ctrl = {ctrlHi_q, arm_q};
	assign regs.ptr  = ptr_q;
endmodule // transfer_set

//--- logic/usb_host_transfer_launch.sv
// host transfer launch logic with two overlapped register sets
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - preamble bit one sends preamble before packet
// - direct low-speed mode ignores the preamble bit
// - toggle picks DATA0/DATA1, OUT transactions only
// - frame-aligned bit waits for next SOF
// - isochronous bit marks packet isochronous
// - direction one is OUT, zero is IN
// - enable zero ignores the set despite arm
// - enable and arm launch; completion clears arm
// - buffer pointer gives start of buffer data
// - two sets overlap, completion passes to other
// - second set usable after write to 0FH
// - only arm bit resets to zero
module usb_host_transfer_launch
	import xfer_launch_pkg::*;
(
	// clocking
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       ce,
	// parallel register port pins
	input  wire logic [7:0] cpuAddr,
	input  wire logic [7:0] cpuWrData,
	input  wire logic       cpuWrN,
	input  wire logic       cpuRdN,
	output      logic [7:0] cpuRdData,
	// serial engine status
	input  wire logic       sieIdle,
	input  wire logic       sofSent,
	input  wire logic       xferDone,
	input  wire logic       directLowSpeed,
	// launch to serial engine
	output      logic       launch,
	output      logic       launchSetB,
	output      logic       launchPreamble,
	output      logic       launchToggle,
	output      logic       launchIso,
	output      logic       launchOut,
	output      logic [7:0] launchPointer,
	output      logic       doneSetA,
	output      logic       doneSetB,
	output      logic       fullFeature
);
	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [7:0] addrS1_q, addrS2_q, dataS1_q, dataS2_q;
	logic       wrS1_q, wrS2_q, wrS3_q, rdS1_q, rdS2_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			addrS1_q <= BYTE_RESET;
			addrS2_q <= BYTE_RESET;
			dataS1_q <= BYTE_RESET;
			dataS2_q <= BYTE_RESET;
			wrS1_q   <= STROBE_RESET;
			wrS2_q   <= STROBE_RESET;
			wrS3_q   <= STROBE_RESET;
			rdS1_q   <= STROBE_RESET;
			rdS2_q   <= STROBE_RESET;
		end else if (ce) begin
			addrS1_q <= cpuAddr;
			addrS2_q <= addrS1_q;
			dataS1_q <= cpuWrData;
			dataS2_q <= dataS1_q;
			wrS1_q   <= cpuWrN;
			wrS2_q   <= wrS1_q;
			wrS3_q   <= wrS2_q;
			rdS1_q   <= cpuRdN;
			rdS2_q   <= rdS1_q;
		end
	end

	// falling edge of the synced write strobe
	logic wrStrobe;
	assign wrStrobe = !wrS2_q && wrS3_q;

	//////////////////////////////////////////////////////////////////////////
	// register sets
	set_launch_if setBus [SET_COUNT] ();
	logic [7:0] ctrlA, ctrlB;
	logic       clearA, clearB;

	assign ctrlA = setBus[0].ctrl;
	assign ctrlB = setBus[1].ctrl;

	genvar s;
	generate
		for (s = 0; s < SET_COUNT; s++) begin : gSet
			localparam logic [7:0] CTRL_OFS = (s == 0) ? SET_A_CTRL_OFS : SET_B_CTRL_OFS;
			localparam logic [7:0] PTR_OFS  = (s == 0) ? SET_A_PTR_OFS : SET_B_PTR_OFS;
			assign setBus[s].wrCtrl   = wrStrobe && (addrS2_q == CTRL_OFS);
			assign setBus[s].wrPtr    = wrStrobe && (addrS2_q == PTR_OFS);
			assign setBus[s].wrData   = dataS2_q;
			assign setBus[s].clearArm = (s == 0) ? clearA : clearB;
			transfer_set uSet (
				.mclk  (mclk),
				.reset (reset),
				.ce    (ce),
				.regs  (setBus[s])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// launch sequencing
	launch_state_t state_q, state_d;
	logic       activeB_q, activeB_d, lastB_q, lastB_d, feature_q, feature_d;
	logic       launch_d, preamble_d, toggle_d, iso_d, out_d, doneA_d, doneB_d;
	logic [7:0] pointer_d, rdData_d;
	logic       readyA, readyB, pickB;
	logic [7:0] pickCtrl, pickPtr;

	assign readyA   = ctrlA[ENABLE_BIT] && ctrlA[ARM_BIT];
	assign readyB   = feature_q && ctrlB[ENABLE_BIT] && ctrlB[ARM_BIT];
	assign pickB    = readyB && (!readyA || !lastB_q);
	assign pickCtrl = pickB ? ctrlB : ctrlA;
	assign pickPtr  = pickB ? setBus[1].ptr : setBus[0].ptr;

	// next state and launch fields
	always_comb begin
		state_d    = state_q;
		activeB_d  = activeB_q;
		lastB_d    = lastB_q;
		feature_d  = feature_q || (wrStrobe && addrS2_q == FEATURE_OFS);
		launch_d   = 1'b0;
		preamble_d = launchPreamble;
		toggle_d   = launchToggle;
		iso_d      = launchIso;
		out_d      = launchOut;
		pointer_d  = launchPointer;
		doneA_d    = 1'b0;
		doneB_d    = 1'b0;
		clearA     = 1'b0;
		clearB     = 1'b0;
		unique case (state_q)
			LAUNCH_IDLE, LAUNCH_WAIT_SOF: begin
				if (!(readyA || readyB)) begin
					state_d = LAUNCH_IDLE;
				end else if (pickCtrl[SOF_SYNC_BIT] && !(state_q == LAUNCH_WAIT_SOF && sofSent)) begin
					state_d = LAUNCH_WAIT_SOF;
				end else if (sieIdle || pickCtrl[SOF_SYNC_BIT]) begin
					state_d    = LAUNCH_BUSY;
					activeB_d  = pickB;
					launch_d   = 1'b1;
					preamble_d = pickCtrl[PREAMBLE_BIT] && !directLowSpeed;
					toggle_d   = pickCtrl[DIR_BIT] && pickCtrl[TOGGLE_BIT];
					iso_d      = pickCtrl[ISO_BIT];
					out_d      = pickCtrl[DIR_BIT];
					pointer_d  = pickPtr;
				end
			end
			LAUNCH_BUSY: begin
				if (xferDone) begin
					state_d = LAUNCH_IDLE;
					lastB_d = activeB_q;
					clearA  = !activeB_q;
					clearB  = activeB_q;
					doneA_d = !activeB_q;
					doneB_d = activeB_q;
				end
			end
			default: state_d = LAUNCH_IDLE;
		endcase
		// read mux, holds while read strobe high
		unique case (addrS2_q)
			SET_A_CTRL_OFS: rdData_d = ctrlA;
			SET_A_PTR_OFS:  rdData_d = setBus[0].ptr;
			SET_B_CTRL_OFS: rdData_d = ctrlB;
			SET_B_PTR_OFS:  rdData_d = setBus[1].ptr;
			default:        rdData_d = UNMAPPED_READ;
		endcase
		if (rdS2_q) begin
			rdData_d = cpuRdData;
		end
	end

	// registered state and outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q        <= LAUNCH_IDLE;
			activeB_q      <= FLAG_RESET;
			lastB_q        <= LAST_B_RESET;
			feature_q      <= FLAG_RESET;
			launch         <= FLAG_RESET;
			launchSetB     <= FLAG_RESET;
			launchPreamble <= FLAG_RESET;
			launchToggle   <= FLAG_RESET;
			launchIso      <= FLAG_RESET;
			launchOut      <= FLAG_RESET;
			launchPointer  <= BYTE_RESET;
			doneSetA       <= FLAG_RESET;
			doneSetB       <= FLAG_RESET;
			fullFeature    <= FLAG_RESET;
			cpuRdData      <= BYTE_RESET;
		end else if (ce) begin
			state_q        <= state_d;
			activeB_q      <= activeB_d;
			lastB_q        <= lastB_d;
			feature_q      <= feature_d;
			launch         <= launch_d;
			launchSetB     <= activeB_d;
			launchPreamble <= preamble_d;
			launchToggle   <= toggle_d;
			launchIso      <= iso_d;
			launchOut      <= out_d;
			launchPointer  <= pointer_d;
			doneSetA       <= doneA_d;
			doneSetB       <= doneB_d;
			fullFeature    <= feature_d;
			cpuRdData      <= rdData_d;
		end
	end
endmodule // usb_host_transfer_launch

//--- bench/launch_asserts.sv
// assertions on the launch block ports
`timescale 1ns/100ps
module launch_asserts (
	// clocking
	input wire logic mclk,
	input wire logic reset,
	// engine status
	input wire logic sieIdle,
	input wire logic sofSent,
	input wire logic xferDone,
	input wire logic directLowSpeed,
	// launch outputs
	input wire logic launch,
	input wire logic launchSetB,
	input wire logic launchPreamble,
	input wire logic launchToggle,
	input wire logic launchOut,
	input wire logic doneSetA,
	input wire logic doneSetB,
	input wire logic fullFeature
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_launch_pulse: assert property (launch |=> !launch) else $error("launch too wide");
	a_launch_cause: assert property (launch |-> $past(sieIdle) || $past(sofSent)) else $error("launch uncaused");
	a_done_cause: assert property (doneSetA || doneSetB |-> $past(xferDone)) else $error("done uncaused");
	a_done_single: assert property (!(doneSetA && doneSetB)) else $error("two sets done");
	a_setb_feature: assert property (launch && launchSetB |-> fullFeature) else $error("set B early");
	a_feature_sticky: assert property (fullFeature |=> fullFeature) else $error("feature lost");
	a_pre_direct: assert property (launch && directLowSpeed |-> !launchPreamble) else $error("preamble");
	a_toggle_in: assert property (launch && !launchOut |-> !launchToggle) else $error("toggle on IN");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=> !launch && !doneSetA && !fullFeature)
		else $error("output after reset");
	c_launch_b: cover property (launch && launchSetB);
	c_preamble: cover property (launch && launchPreamble);
	c_done_a: cover property (doneSetA);
	c_sof_launch: cover property (launch && $past(sofSent));
endmodule // launch_asserts
bind usb_host_transfer_launch launch_asserts launch_asserts_i (.mclk(mclk), .reset(reset), .sieIdle(sieIdle),
	.sofSent(sofSent), .xferDone(xferDone), .directLowSpeed(directLowSpeed), .launch(launch),
	.launchSetB(launchSetB), .launchPreamble(launchPreamble), .launchToggle(launchToggle),
	.launchOut(launchOut), .doneSetA(doneSetA), .doneSetB(doneSetB), .fullFeature(fullFeature));

//--- bench/sie_model.sv
// serial engine model: frame starts and transaction completion
`timescale 1ns/100ps
module sie_model (
	// clocking
	input wire logic mclk,
	input wire logic reset,
	// handshake
	input wire logic launch,
	output logic     sieIdle,
	output logic     sofSent,
	output logic     xferDone
);
	logic [5:0] sofCnt = 6'h00;
	logic [3:0] busyCnt = 4'h0;
	always @(posedge mclk) begin
		sofSent <= sofCnt == 6'h27;
		sofCnt <= (reset || sofCnt == 6'h27) ? 6'h00 : sofCnt + 6'h01;
		xferDone <= 1'b0;
		if (reset) begin
			sieIdle <= 1'b1;
		end else if (launch) begin
			sieIdle <= 1'b0;
			busyCnt <= 4'($urandom_range(9, 1));
		end else if (!sieIdle) begin
			busyCnt <= busyCnt - 4'h1;
			xferDone <= busyCnt == 4'h1;
			sieIdle <= busyCnt == 4'h1;
		end
	end
endmodule // sie_model

//--- bench/testbench.sv
// random and corner tests of the host transfer launch block
`timescale 1ns/100ps
module testbench;
	import xfer_launch_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, cpuWrN = 1'b1, cpuRdN = 1'b1, directLowSpeed = 1'b0, ce = 1'b1;
	logic [7:0] cpuAddr = 8'h00, cpuWrData = 8'h00, cpuRdData, launchPointer, rv, c, p, capPtr;
	logic sieIdle, sofSent, xferDone, launch, launchSetB, launchPreamble, launchToggle, launchIso, launchOut;
	logic doneSetA, doneSetB, fullFeature, d, sof1, capSof, capB, capDB;
	logic [3:0] capF;
	int err_total = 0, comparisons = 0, nLaunch = 0, nDone = 0;
	always #10 mclk = ~mclk;
	usb_host_transfer_launch usb_host_transfer_launch_i (.mclk(mclk), .reset(reset), .ce(ce),
		.cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuWrN(cpuWrN), .cpuRdN(cpuRdN), .cpuRdData(cpuRdData),
		.sieIdle(sieIdle), .sofSent(sofSent), .xferDone(xferDone), .directLowSpeed(directLowSpeed),
		.launch(launch), .launchSetB(launchSetB), .launchPreamble(launchPreamble), .launchToggle(launchToggle),
		.launchIso(launchIso), .launchOut(launchOut), .launchPointer(launchPointer), .doneSetA(doneSetA),
		.doneSetB(doneSetB), .fullFeature(fullFeature));
	sie_model sie_model_i (.mclk(mclk), .reset(reset), .launch(launch), .sieIdle(sieIdle), .sofSent(sofSent),
		.xferDone(xferDone));
	always @(posedge mclk) begin
		sof1 <= sofSent;
		if (launch) begin
			nLaunch <= nLaunch + 1;
			capSof <= sof1;
			capB <= launchSetB;
			capPtr <= launchPointer;
			capF <= {launchPreamble, launchToggle, launchIso, launchOut};
		end
		if (doneSetA || doneSetB) begin
			nDone <= nDone + 1;
			capDB <= doneSetB;
		end
	end
	function automatic logic [7:0] fields(input logic [7:0] cb, input logic dl);
		return {4'h0, cb[7] & ~dl, cb[6] & cb[2], cb[4], cb[2]};
	endfunction
	task automatic stop_test(input bit hung);
		if (hung) err_total++;
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		cpuAddr <= a;
		cpuWrData <= v;
		cpuWrN <= 1'b0;
		repeat (4) @(posedge mclk);
		cpuWrN <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a);
		cpuAddr <= a;
		cpuRdN <= 1'b0;
		repeat (5) @(posedge mclk);
		rv = cpuRdData;
		cpuRdN <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic waitFor(ref int cnt, input int want);
		for (int k = 0; k < 300 && cnt < want; k++)
			@(posedge mclk);
		if (cnt < want) stop_test(1'b1);
	endtask
	initial begin
		void'($urandom(32'h7E71F1F7));
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		rd(SET_A_CTRL_OFS);
		chk({7'h00, rv[ARM_BIT]}, {7'h00, ARM_RESET});
		rd(8'h05);
		chk(rv, UNMAPPED_READ);
		wr(SET_B_PTR_OFS, 8'h5A);
		wr(SET_B_CTRL_OFS, 8'h03);
		wr(SET_A_CTRL_OFS, 8'h01);
		repeat (20) @(posedge mclk);
		chk(8'(nLaunch), 8'h00);
		chk({7'h00, fullFeature}, 8'h00);
		wr(FEATURE_OFS, 8'h00);
		chk({7'h00, fullFeature}, 8'h01);
		waitFor(nLaunch, 1);
		chk({capB, capPtr[6:0]}, 8'hDA);
		waitFor(nDone, 1);
		rd(SET_B_CTRL_OFS);
		chk(rv, 8'h02);
		$display("feature test done");
		for (int i = 0; i < 24; i++) begin
			c = (i == 2) ? 8'hFF : 8'($urandom()) | 8'h03;
			p = 8'($urandom());
			d = (i == 2) ? 1'b0 : 1'($urandom());
			if (d) c[SOF_SYNC_BIT] = 1'b0;
			c[RSVD_BIT] = 1'b0;
			directLowSpeed <= d;
			wr(i[0] ? SET_B_PTR_OFS : SET_A_PTR_OFS, p);
			wr(i[0] ? SET_B_CTRL_OFS : SET_A_CTRL_OFS, c);
			waitFor(nLaunch, i + 2);
			chk({7'h00, capB}, {7'h00, i[0]});
			chk(capPtr, p);
			chk({4'h0, capF}, fields(c, d));
			if (c[SOF_SYNC_BIT]) chk({7'h00, capSof}, 8'h01);
			waitFor(nDone, i + 2);
			chk({7'h00, capDB}, {7'h00, i[0]});
			rd(i[0] ? SET_B_CTRL_OFS : SET_A_CTRL_OFS);
			chk(rv, c & 8'hFE);
			$display("test %0d done", i);
		end
		directLowSpeed <= 1'b0;
		for (int k = 0; k < 60 && !sofSent; k++)
			@(posedge mclk);
		if (!sofSent) stop_test(1'b1);
		wr(SET_A_CTRL_OFS, 8'h23);
		wr(SET_B_CTRL_OFS, 8'h23);
		chk(8'(nLaunch), 8'h19);
		waitFor(nLaunch, 26);
		chk({7'h00, capB}, 8'h00);
		chk({7'h00, capSof}, 8'h01);
		waitFor(nLaunch, 27);
		chk({7'h00, capB}, 8'h01);
		chk({7'h00, capSof}, 8'h01);
		waitFor(nDone, 27);
		chk({7'h00, capDB}, 8'h01);
		$display("overlap test done");
		ce <= 1'b0;
		wr(SET_A_CTRL_OFS, 8'h03);
		ce <= 1'b1;
		rd(SET_A_CTRL_OFS);
		chk(rv, 8'h22);
		chk(8'(nLaunch), 8'h1B);
		$display("clock enable test done");
		stop_test(1'b0);
	end
endmodule // testbench
